// >>> pamask_bench.sv
/*
 testbench for pamask_top: register access, per-bit gating on all slices, irq.
 assumes: pamask_map.vh on the include path; pamask_chk compiled before.
*/
`timescale 1ns/1ns
`include "pamask_map.vh"
module pamask_bench;
  logic        clk_sys_i = 1'b0;
  logic        reset_n_i = 1'b0;
  logic [55:0] src = '0;
  logic [13:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_o;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [3:0]  receive_alarm_out_o, aisp_request_o;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        clk_en = 1'b1;
  logic [7:0]  outs;
  assign outs = {receive_alarm_out_o, aisp_request_o};
  int          n_fail = 0, cmp_count = 0, cyc = 0;

  // src: sect 3:0, master sect 7:4, line ais 11:8, master line ais 15:12, defects 55:16
  pamask_top i_pamask_top (.clk_sys_i, .reset_n_i, .clk_en_i(clk_en), .sect_alarm_i(src[3:0]),
    .master_sect_alarm_i(src[7:4]), .line_ais_ins_i(src[11:8]), .master_line_ais_ins_i(src[15:12]),
    .path_defect_i(src[55:16]), .receive_alarm_out_o, .aisp_request_o, .irq_o, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

  initial forever #25 clk_sys_i = ~clk_sys_i;

  task automatic give_verdict();
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d, output logic [1:0] r);
    bit aw_ok;
    bit w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      @(posedge clk_sys_i);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      s_axi_awvalid <= !aw_ok;
      s_axi_wvalid <= !w_ok;
    end
    while (!s_axi_bvalid) @(posedge clk_sys_i);
    s_axi_bready <= 1'b1;
    @(posedge clk_sys_i);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk_sys_i); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge clk_sys_i);
    s_axi_rready <= 1'b1;
    @(posedge clk_sys_i);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      give_verdict();
    end
  end

  initial begin
    int          s, k, b;
    logic [31:0] d;
    logic [1:0]  r;
    logic [13:0] a;
    repeat (6) @(posedge clk_sys_i);
    reset_n_i <= 1'b1;
    @(posedge clk_sys_i);
    // even s: alarm mask, odd s: AIS-P mask, slice s/2
    for (s = 0; s < 8; s++) begin
      a = 14'h09a4 + 14'(s >> 1) * 14'h1000 + 14'(s & 1) * 14'h4;
      rd(a, d, r);
      chk(d, 32'h0);
      wr(a, 32'h0000_c000 | 32'(s + 1), r);
    end
    for (s = 0; s < 8; s++) begin
      a = 14'h09a4 + 14'(s >> 1) * 14'h1000 + 14'(s & 1) * 14'h4;
      rd(a, d, r);
      chk(d, 32'(s + 1));
      wr(a, 32'h0, r);
    end
    rd(14'h0004, d, r);
    chk({d[29:0], r}, 32'(`PAMASK_RESP_SLVERR));
    wr(14'h0004, 32'h1, r);
    chk(r, 32'(`PAMASK_RESP_SLVERR));
    // only the upper byte lane is written
    s_axi_wstrb <= 4'h2;
    wr(14'h09a4, 32'h0fff, r);
    s_axi_wstrb <= 4'hf;
    rd(14'h09a4, d, r);
    chk(d, 32'h0f00);
    wr(14'h09a4, 32'h0, r);
    for (s = 0; s < 4; s++)
      for (k = 0; k < 2; k++)
        for (b = 0; b < 12; b++) begin
          if (k == 1 && (b == 8 || b == 9))
            continue;
          a = 14'h09a4 + 14'(s) * 14'h1000 + 14'(k) * 14'h4;
          src <= 56'h1 << (b < 2 ? 4 * (b + 2 * k) + s : 16 + 10 * s + b - 2);
          wr(a, 32'h1 << b, r);
          repeat (5) @(posedge clk_sys_i);
          if (k == 0)
            chk(outs, 32'h10 << s);
          else
            chk(outs, 32'h1 << s);
          wr(a, (k ? 32'h0cff : 32'h0fff) & ~(32'h1 << b), r);
          repeat (5) @(posedge clk_sys_i);
          chk(outs, 32'h0);
          wr(a, 32'h0, r);
        end
    // clock enable low must freeze the defect path
    wr(14'h09a4, 32'h4, r);
    clk_en <= 1'b0;
    src <= 56'h1 << 16;
    repeat (6) @(posedge clk_sys_i);
    chk(outs, 32'h0);
    clk_en <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    chk(outs, 32'h10);
    src <= '0;
    wr(14'h09a4, 32'h0, r);
    rd(14'h03c0, d, r);
    chk(d, 32'hff);
    chk(irq_o, 32'h0);
    wr(14'h03c4, 32'hff, r);
    repeat (3) @(posedge clk_sys_i);
    chk(irq_o, 32'h1);
    wr(14'h03c0, 32'hff, r);
    rd(14'h03c0, d, r);
    chk(d, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    chk(irq_o, 32'h0);
    give_verdict();
  end
endmodule

bind pamask_top pamask_chk i_pamask_chk (.clk_sys_i, .reset_n_i, .sect_alarm_i, .master_sect_alarm_i,
  .line_ais_ins_i, .master_line_ais_ins_i, .path_defect_i, .receive_alarm_out_o, .aisp_request_o,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);

// >>> pamask_chk.sv
/*
 checker for pamask_top: bus handshake timing and hold, quiet outputs.
 assumes: bound to pamask_top by name from the bench top file.
*/
`timescale 1ns/1ns
module pamask_chk (
  input logic        clk_sys_i,
  input logic        reset_n_i,
  input logic [3:0]  sect_alarm_i,
  input logic [3:0]  master_sect_alarm_i,
  input logic [3:0]  line_ais_ins_i,
  input logic [3:0]  master_line_ais_ins_i,
  input logic [39:0] path_defect_i,
  input logic [3:0]  receive_alarm_out_o,
  input logic [3:0]  aisp_request_o,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!reset_n_i);

  property p_wr; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
  a_wr: assert property (p_wr) else $error("write response late");
  property p_rd; s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid; endproperty
  a_rd: assert property (p_rd) else $error("read response late");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read response dropped");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
  a_bdone: assert property (p_bdone) else $error("write response repeated");
  property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
  a_rdone: assert property (p_rdone) else $error("read response repeated");
  property p_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_busy: assert property (p_busy) else $error("ready while response pends");
  property p_rup; s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000; endproperty
  a_rup: assert property (p_rup) else $error("upper read bits set");
  property p_quiet; (sect_alarm_i == 4'h0 && master_sect_alarm_i == 4'h0 && line_ais_ins_i == 4'h0
    && master_line_ais_ins_i == 4'h0 && path_defect_i == 40'h0)[*4]
    |-> receive_alarm_out_o == 4'h0 && aisp_request_o == 4'h0; endproperty
  a_quiet: assert property (p_quiet) else $error("output active without source");
endmodule

// >>> pamask_gate.v
/*
 one slice: gates the defect and alarm sources by the two masks and ORs them.
 assumes: sources are already synchronised; masks come from the register file.
*/
`timescale 1ns/1ns
`include "pamask_map.vh"

module pamask_gate (
  input  wire        sect_alarm_i,
  input  wire        master_sect_alarm_i,
  input  wire        line_ais_ins_i,
  input  wire        master_line_ais_ins_i,
  input  wire [9:0]  path_defect_i,
  input  wire [15:0] alarm_mask_i,
  input  wire [15:0] aisp_mask_i,
  output wire        alarm_o,
  output wire        aisp_o
);
  // path_defect_i bit k holds the defect of mask bit k+2
  wire [15:0] alm_src;
  wire [15:0] aisp_src;

  assign alm_src  = {4'h0, path_defect_i, master_sect_alarm_i, sect_alarm_i};
  // rdi and erdi do not feed AIS-P; those bits are reserved there
  assign aisp_src = {4'h0, path_defect_i[9:8], 2'b00, path_defect_i[5:0],
                     master_line_ais_ins_i, line_ais_ins_i};

  assign alarm_o = |(alm_src & alarm_mask_i);
  assign aisp_o  = |(aisp_src & aisp_mask_i);
endmodule

// >>> pamask_map.vh
/*
 register map, field positions, reset values and source bit layout of the
 path alarm / AIS-P enable mask bank.
 assumes: included by the pamask design files by bare name.
*/
`ifndef PAMASK_MAP_VH
`define PAMASK_MAP_VH

// register indices; byte address is four times the index
`define PAMASK_IDX_ALM_S0   12'h269
`define PAMASK_IDX_ALM_S1   12'h669
`define PAMASK_IDX_ALM_S2   12'ha69
`define PAMASK_IDX_ALM_S3   12'he69
`define PAMASK_IDX_AISP_S0  12'h26a
`define PAMASK_IDX_AISP_S1  12'h66a
`define PAMASK_IDX_AISP_S2  12'ha6a
`define PAMASK_IDX_AISP_S3  12'he6a
`define PAMASK_IDX_SLICE_LO 10'h269
`define PAMASK_IDX_SLICE_HI 10'h26a
`define PAMASK_IDX_IRQ_STAT 12'h0f0
`define PAMASK_IDX_IRQ_MASK 12'h0f1

// writable field of each mask register (bits 15:14 unused)
`define PAMASK_WR_MASK      16'h3fff
`define PAMASK_RST_VAL      16'h0000

// bit positions of the receive alarm mask
`define PAMASK_ALM_SECT     0
`define PAMASK_ALM_MSECT    1
// bit positions of the AIS-P mask
`define PAMASK_AISP_LAIS    0
`define PAMASK_AISP_MLAIS   1
// positions shared by both masks, except RDI and ERDI, which gate the alarm only
`define PAMASK_LOP          2
`define PAMASK_AISPTR       3
`define PAMASK_PLU          4
`define PAMASK_PLM          5
`define PAMASK_UNEQ         6
`define PAMASK_PDI          7
`define PAMASK_RDI          8
`define PAMASK_ERDI         9
`define PAMASK_TIU          10
`define PAMASK_TIM          11

// interrupt status bits, one alarm and one AIS-P rise per slice
`define PAMASK_IRQ_W        8
`define PAMASK_IRQ_ALM_LSB  0
`define PAMASK_IRQ_AISP_LSB 4

// axi response codes
`define PAMASK_RESP_OKAY    2'b00
`define PAMASK_RESP_SLVERR  2'b10

`endif

// >>> pamask_sync.v
/*
 two flip-flop synchroniser for a bundle of level inputs.
 assumes: inputs are quasi-static defect levels from outside the clock domain.
*/
`timescale 1ns/1ns
`include "pamask_map.vh"

module pamask_sync #(
  parameter W = 16
) (
  input  wire         clk_sys_i,
  input  wire         reset_n_i,
  input  wire         clk_en_i,
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);
  reg [W-1:0] stage1;
  reg [W-1:0] stage2;

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      stage1 <= {W{1'b0}};
      stage2 <= {W{1'b0}};
    end else if (clk_en_i) begin
      stage1 <= async_i;
      stage2 <= stage1;
    end
  end

  assign sync_o = stage2;
endmodule

// >>> pamask_top.v
/*
 path receive alarm and AIS-P enable mask bank, four slices, AXI4-Lite slave,
 with sticky interrupt status on rising alarm and AIS-P requests.
 assumes: defect and alarm inputs arrive asynchronously as levels;
 the bus master keeps at most one write and one read outstanding.
*/
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "pamask_map.vh"

// Function
// - master section alarm reaches the alarm output only while its enable is set
// - loss-of-pointer defect reaches the alarm output only while enabled
// - AIS pointer defect reaches the alarm output only while enabled
// - label unstable and label mismatch each gated by its own alarm enable
// - unequipped and payload defect indication each gated by own alarm enable
// - remote and enhanced remote defect each gated by own alarm enable
// - trace unstable and trace mismatch each gated by own alarm enable
// - AIS-P bit 0 gates line AIS insertion into AIS-P generation
// - AIS-P bit 1 gates master line AIS insertion into AIS-P generation
// - AIS-P bits 2 and 3 gate loss-of-pointer and AIS pointer defects
// - AIS-P bits 4 and 5 gate label unstable and label mismatch
// - AIS-P bits 6 and 7 gate unequipped and payload defect indication
// - AIS-P bits 10 and 11 gate trace unstable and trace mismatch
// - each of four slices has its own AIS-P mask at its own address
// - alarm bit 0 gates the receive section alarm into the alarm output
// - each of four slices has its own receive alarm mask register
module pamask_top (
  input  wire        clk_sys_i,
  input  wire        reset_n_i,
  input  wire        clk_en_i,
  input  wire [3:0]  sect_alarm_i,
  input  wire [3:0]  master_sect_alarm_i,
  input  wire [3:0]  line_ais_ins_i,
  input  wire [3:0]  master_line_ais_ins_i,
  input  wire [39:0] path_defect_i,
  output reg  [3:0]  receive_alarm_out_o,
  output reg  [3:0]  aisp_request_o,
  output reg         irq_o,
  input  wire [13:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [13:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready
);
  integer i;

  reg  [15:0] alarm_mask [0:3];
  reg  [15:0] aisp_mask  [0:3];
  reg  [`PAMASK_IRQ_W-1:0] irq_stat;
  reg  [`PAMASK_IRQ_W-1:0] irq_mask;

  wire [55:0] src_sync;
  wire [3:0]  next_alarm;
  wire [3:0]  next_aisp;

  // write channel capture
  reg         aw_held;
  reg         w_held;
  reg  [11:0] aw_idx;
  reg  [31:0] w_data;
  reg  [3:0]  w_strb;

  pamask_sync #(
    .W (56)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .reset_n_i (reset_n_i),
    .clk_en_i  (clk_en_i),
    .async_i   ({path_defect_i, master_line_ais_ins_i, line_ais_ins_i,
                 master_sect_alarm_i, sect_alarm_i}),
    .sync_o    (src_sync)
  );

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_slice
      pamask_gate u_gate (
        .sect_alarm_i          (src_sync[g]),
        .master_sect_alarm_i   (src_sync[4+g]),
        .line_ais_ins_i        (src_sync[8+g]),
        .master_line_ais_ins_i (src_sync[12+g]),
        .path_defect_i         (src_sync[16+10*g +: 10]),
        .alarm_mask_i          (alarm_mask[g]),
        .aisp_mask_i           (aisp_mask[g]),
        .alarm_o               (next_alarm[g]),
        .aisp_o                (next_aisp[g])
      );
    end
  endgenerate

  // slice decode: bits 11:10 of the index pick the slice
  function [2:0] idx_decode;
    input [11:0] idx;
    begin
      if (idx[9:0] == `PAMASK_IDX_SLICE_LO)
        idx_decode = 3'b001;
      else if (idx[9:0] == `PAMASK_IDX_SLICE_HI)
        idx_decode = 3'b010;
      else if (idx == `PAMASK_IDX_IRQ_STAT)
        idx_decode = 3'b011;
      else if (idx == `PAMASK_IDX_IRQ_MASK)
        idx_decode = 3'b100;
      else
        idx_decode = 3'b000;
    end
  endfunction

  wire        wr_fire;
  wire [2:0]  wr_sel;
  wire [1:0]  wr_slice;
  wire [15:0] wr_bits;
  wire [15:0] wr_lane;

  assign wr_fire  = aw_held && w_held && !s_axi_bvalid;
  assign wr_sel   = idx_decode(aw_idx);
  assign wr_slice = aw_idx[11:10];
  assign wr_lane  = {{8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_bits  = w_data[15:0];

  // sticky events: rising edge of each slice's alarm and AIS-P request
  wire [`PAMASK_IRQ_W-1:0] irq_event;
  wire [`PAMASK_IRQ_W-1:0] irq_clr;

  assign irq_event = {next_aisp & ~aisp_request_o, next_alarm & ~receive_alarm_out_o};
  assign irq_clr   = (wr_fire && wr_sel == 3'b011 && w_strb[0]) ? w_data[`PAMASK_IRQ_W-1:0]
                                                                 : {`PAMASK_IRQ_W{1'b0}};

  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      receive_alarm_out_o <= 4'h0;
      aisp_request_o      <= 4'h0;
      irq_stat            <= {`PAMASK_IRQ_W{1'b0}};
      irq_o               <= 1'b0;
    end else if (clk_en_i) begin
      receive_alarm_out_o <= next_alarm;
      aisp_request_o      <= next_aisp;
      // set wins over a clear in the same cycle
      irq_stat            <= (irq_stat & ~irq_clr) | irq_event;
      irq_o               <= |(irq_stat & irq_mask);
    end
  end

  // write path
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      aw_held       <= 1'b0;
      w_held        <= 1'b0;
      aw_idx        <= 12'h000;
      w_data        <= 32'h0000_0000;
      w_strb        <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `PAMASK_RESP_OKAY;
      irq_mask      <= {`PAMASK_IRQ_W{1'b0}};
      for (i = 0; i < 4; i = i + 1) begin
        alarm_mask[i] <= `PAMASK_RST_VAL;
        aisp_mask[i]  <= `PAMASK_RST_VAL;
      end
    end else if (clk_en_i) begin
      s_axi_awready <= !aw_held && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held       <= 1'b1;
        aw_idx        <= s_axi_awaddr[13:2];
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held       <= 1'b1;
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_held      <= 1'b0;
        w_held       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_sel == 3'b000) ? `PAMASK_RESP_SLVERR : `PAMASK_RESP_OKAY;
        // bits 13:12 are stored as written, bits 15:14 never; software keeps reserved bits zero
        case (wr_sel)
          3'b001: begin
            alarm_mask[wr_slice] <= (alarm_mask[wr_slice] & ~(wr_lane & `PAMASK_WR_MASK))
                                  | (wr_bits & wr_lane & `PAMASK_WR_MASK);
          end
          3'b010: begin
            aisp_mask[wr_slice] <= (aisp_mask[wr_slice] & ~(wr_lane & `PAMASK_WR_MASK))
                                 | (wr_bits & wr_lane & `PAMASK_WR_MASK);
          end
          3'b100: begin
            if (w_strb[0])
              irq_mask <= w_data[`PAMASK_IRQ_W-1:0];
          end
          default: begin
          end
        endcase
      end
      if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // read path
  always @(posedge clk_sys_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `PAMASK_RESP_OKAY;
    end else if (clk_en_i) begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= (idx_decode(s_axi_araddr[13:2]) == 3'b000) ? `PAMASK_RESP_SLVERR
                                                                    : `PAMASK_RESP_OKAY;
        case (idx_decode(s_axi_araddr[13:2]))
          3'b001:  s_axi_rdata <= {16'h0000, alarm_mask[s_axi_araddr[13:12]]};
          3'b010:  s_axi_rdata <= {16'h0000, aisp_mask[s_axi_araddr[13:12]]};
          3'b011:  s_axi_rdata <= {24'h000000, irq_stat};
          3'b100:  s_axi_rdata <= {24'h000000, irq_mask};
          default: s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
